// *** design/vbc_band_cal.sv ***
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
// Contract
// - A trigger write with the calibration enable bit at one launches the band search unless the band override bit is set.
// - Every trigger write also launches the amplitude calibration unless the amplitude override bit is set.
// - The search picks one band among several covering 7600 to 15200 MHz.
// - With partial assistance the search starts from the host supplied core.
// - With full assistance the supplied core, band and amplitude are applied without search.
// - With the watchdog enabled a timer runs during each calibration.
// - Watchdog expiry before the restart count is reached aborts the calibration and restarts it from the beginning.
// - Watchdog restarts never exceed the programmed restart count.
// - With the relock pin high, loss of lock lasting the lock delay triggers a recalibration.
// - The lock delay is a 16 bit count of phase detector cycles used for lock and recalibration.
module vbc_band_cal import vbc_pkg::*; #(
  parameter int WD_TIMEOUT_CYCLES = WD_TIMEOUT_DEFAULT
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire vbc_bus_type bus_i,
  output logic [15:0] rd_data_o,
  input wire logic freq_above_i,
  input wire logic amp_low_i,
  input wire logic lock_i,
  input wire logic pd_tick_i,
  input wire logic relock_cal_pin_i,
  output vbc_osc_type osc_o,
  output logic cal_busy_o,
  output logic lock_detect_o,
  output logic irq_o
);

  vbc_state_type s;
  vbc_state_type next_s;

  always_comb begin
    logic pd_edge;
    logic do_start;
    logic do_band;
    logic fresh;
    logic keep;
    logic [3:0] ev;
    logic [3:0] clr;
    logic [7:0] trial;
    pd_edge = 1'b0;
    do_start = 1'b0;
    do_band = 1'b0;
    fresh = 1'b0;
    keep = 1'b0;
    ev = 4'h0;
    clr = 4'h0;
    trial = 8'h00;
    next_s = s;

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    next_s.sync1 = {relock_cal_pin_i, pd_tick_i, lock_i, amp_low_i, freq_above_i};
    next_s.sync2 = s.sync1;
    next_s.pd_prev = s.sync2[SYN_PD];
    pd_edge = s.sync2[SYN_PD] & ~s.pd_prev;

    // ---------------------------------------------------------------
    // Register access
    // ---------------------------------------------------------------
    next_s.rd_data = 16'h0000;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        OFS_TRIGGER: next_s.rd_data[TRIG_FCAL_BIT] = s.trig_fcal;
        OFS_ASSIST: next_s.rd_data[6:0] = {s.wd_enable, s.amp_override, s.band_override,
                                           s.core_override, s.start_core};
        OFS_MANUAL: next_s.rd_data = {s.manual_amp, s.manual_band};
        OFS_WATCHDOG: next_s.rd_data = {s.wd_restarts, s.wd_restart_count};
        OFS_LOCK_DELAY: next_s.rd_data = s.lock_delay_count;
        OFS_RESULT: begin
          next_s.rd_data[RESULT_BUSY_BIT] = s.busy;
          next_s.rd_data[RESULT_LD_BIT] = s.ld_ok;
          next_s.rd_data[10:0] = {s.osc.core, s.osc.band};
        end
        OFS_AMP_RESULT: next_s.rd_data[7:0] = s.osc.amp;
        OFS_IRQ_STATUS: next_s.rd_data[3:0] = s.irq_status;
        OFS_IRQ_MASK: next_s.rd_data[3:0] = s.irq_mask;
        default: next_s.rd_data = 16'h0000;
      endcase
    end
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        OFS_TRIGGER: begin
          next_s.trig_fcal = bus_i.wdata[TRIG_FCAL_BIT];
          do_start = 1'b1;
          do_band = bus_i.wdata[TRIG_FCAL_BIT];
          fresh = 1'b1;
        end
        OFS_ASSIST: begin
          next_s.start_core = bus_i.wdata[ASSIST_CORE_LSB +: 3];
          next_s.core_override = bus_i.wdata[ASSIST_CORE_OVR_BIT];
          next_s.band_override = bus_i.wdata[ASSIST_BAND_OVR_BIT];
          next_s.amp_override = bus_i.wdata[ASSIST_AMP_OVR_BIT];
          next_s.wd_enable = bus_i.wdata[ASSIST_WD_EN_BIT];
        end
        OFS_MANUAL: begin
          next_s.manual_band = bus_i.wdata[7:0];
          next_s.manual_amp = bus_i.wdata[15:8];
        end
        OFS_WATCHDOG: next_s.wd_restart_count = bus_i.wdata[7:0];
        OFS_LOCK_DELAY: next_s.lock_delay_count = bus_i.wdata;
        OFS_IRQ_STATUS: clr = bus_i.wdata[3:0];
        OFS_IRQ_MASK: next_s.irq_mask = bus_i.wdata[3:0];
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // Calibration sequencer
    // ---------------------------------------------------------------
    unique case (s.fsm)
      ST_IDLE: ;
      ST_BAND: begin
        if (s.settle != 3'(SETTLE_CYCLES - 1)) begin
          next_s.settle = s.settle + 3'h1;
        end else begin
          next_s.settle = 3'h0;
          // A set bit adds capacitance and lowers the frequency.
          keep = s.sync2[SYN_FREQ];
          trial = s.osc.band;
          trial[s.bit_idx] = keep;
          next_s.osc.band = trial;
          if (s.bit_idx == 3'h0) begin
            if (trial == SAR_TOP && keep && s.osc.core > MIN_CORE && !s.core_override) begin
              next_s.osc.core = s.osc.core - 3'h1;
              next_s.osc.band = SAR_MID;
              next_s.bit_idx = SAR_MSB;
            end else begin
              next_s.fsm = ST_AMP_START;
            end
          end else begin
            next_s.bit_idx = s.bit_idx - 3'h1;
            next_s.osc.band[s.bit_idx - 3'h1] = 1'b1;
          end
        end
      end
      ST_AMP_START: begin
        if (s.amp_override) begin
          next_s.osc.amp = s.manual_amp;
          next_s.fsm = ST_IDLE;
          next_s.busy = 1'b0;
          ev[EV_DONE] = 1'b1;
        end else begin
          next_s.osc.amp = SAR_MID;
          next_s.bit_idx = SAR_MSB;
          next_s.settle = 3'h0;
          next_s.fsm = ST_AMP;
        end
      end
      ST_AMP: begin
        if (s.settle != 3'(SETTLE_CYCLES - 1)) begin
          next_s.settle = s.settle + 3'h1;
        end else begin
          next_s.settle = 3'h0;
          trial = s.osc.amp;
          trial[s.bit_idx] = s.sync2[SYN_AMP];
          next_s.osc.amp = trial;
          if (s.bit_idx == 3'h0) begin
            next_s.fsm = ST_IDLE;
            next_s.busy = 1'b0;
            ev[EV_DONE] = 1'b1;
          end else begin
            next_s.bit_idx = s.bit_idx - 3'h1;
            next_s.osc.amp[s.bit_idx - 3'h1] = 1'b1;
          end
        end
      end
    endcase

    // ---------------------------------------------------------------
    // Watchdog
    // ---------------------------------------------------------------
    // A host trigger in the same cycle as an expiry wins, so its mode is not overwritten.
    if (s.busy && s.wd_enable && !s.wd_spent && !do_start) begin
      next_s.wd_timer = s.wd_timer + 16'h0001;
      if (s.wd_timer == 16'(WD_TIMEOUT_CYCLES - 1)) begin
        next_s.wd_timer = 16'h0000;
        if (s.wd_restarts < s.wd_restart_count) begin
          next_s.wd_restarts = s.wd_restarts + 8'h01;
          do_start = 1'b1;
          do_band = s.band_run;
          ev[EV_WD_RESTART] = 1'b1;
        end else begin
          next_s.wd_spent = 1'b1;
          ev[EV_WD_EXHAUSTED] = 1'b1;
        end
      end
    end

    // ---------------------------------------------------------------
    // Lock delay and recalibration on loss of lock
    // ---------------------------------------------------------------
    if (!s.busy && !s.ld_ok && pd_edge) begin
      next_s.ld_timer = s.ld_timer + 16'h0001;
    end
    if (!s.busy && !s.ld_ok && s.ld_timer == s.lock_delay_count) begin
      next_s.ld_ok = 1'b1;
    end
    if (s.sync2[SYN_RELOCK] && s.ld_ok && !s.sync2[SYN_LOCK]) begin
      if (pd_edge) begin
        next_s.unlock_timer = s.unlock_timer + 16'h0001;
      end
      if (s.unlock_timer == s.lock_delay_count && !do_start) begin
        do_start = 1'b1;
        do_band = 1'b1;
        fresh = 1'b1;
        ev[EV_RECAL] = 1'b1;
      end
    end else begin
      next_s.unlock_timer = 16'h0000;
    end

    // ---------------------------------------------------------------
    // Launch, which overrides any calibration in progress
    // ---------------------------------------------------------------
    if (do_start) begin
      next_s.busy = 1'b1;
      next_s.band_run = do_band;
      next_s.wd_timer = 16'h0000;
      next_s.ld_timer = 16'h0000;
      next_s.unlock_timer = 16'h0000;
      next_s.ld_ok = 1'b0;
      next_s.settle = 3'h0;
      next_s.bit_idx = SAR_MSB;
      if (fresh) begin
        next_s.wd_restarts = 8'h00;
        next_s.wd_spent = 1'b0;
      end
      if (!do_band) begin
        next_s.fsm = ST_AMP_START;
      end else if (s.band_override) begin
        next_s.osc.core = s.start_core;
        next_s.osc.band = s.manual_band;
        next_s.fsm = ST_AMP_START;
      end else begin
        next_s.osc.core = s.start_core;
        next_s.osc.band = SAR_MID;
        next_s.fsm = ST_BAND;
      end
    end

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    next_s.irq_status = (s.irq_status & ~clr) | ev;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.start_core <= RST_START_CORE;
      s.wd_restart_count <= RST_WD_COUNT;
      s.lock_delay_count <= RST_LOCK_DELAY;
      s.fsm <= ST_IDLE;
      s.osc.core <= RST_START_CORE;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rd_data;
  assign osc_o = s.osc;
  assign cal_busy_o = s.busy;
  assign lock_detect_o = s.ld_ok;
  assign irq_o = s.irq;

endmodule // vbc_band_cal

// *** design/vbc_pkg.sv ***
package vbc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_TIME_NS = 400;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_TIMEOUT_DEFAULT = 4000;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_TRIGGER = 8'h00;
  localparam logic [7:0] OFS_ASSIST = 8'h04;
  localparam logic [7:0] OFS_MANUAL = 8'h08;
  localparam logic [7:0] OFS_WATCHDOG = 8'h0C;
  localparam logic [7:0] OFS_LOCK_DELAY = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_AMP_RESULT = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TRIG_FCAL_BIT = 0;
  localparam int ASSIST_CORE_LSB = 0;
  localparam int ASSIST_CORE_OVR_BIT = 3;
  localparam int ASSIST_BAND_OVR_BIT = 4;
  localparam int ASSIST_AMP_OVR_BIT = 5;
  localparam int ASSIST_WD_EN_BIT = 6;
  localparam int RESULT_LD_BIT = 14;
  localparam int RESULT_BUSY_BIT = 15;
  localparam int EV_DONE = 0;
  localparam int EV_WD_RESTART = 1;
  localparam int EV_RECAL = 2;
  localparam int EV_WD_EXHAUSTED = 3;
  localparam int SYN_FREQ = 0;
  localparam int SYN_AMP = 1;
  localparam int SYN_LOCK = 2;
  localparam int SYN_PD = 3;
  localparam int SYN_RELOCK = 4;

  // ---------------------------------------------------------------
  // Reset and search values
  // ---------------------------------------------------------------
  localparam logic [2:0] RST_START_CORE = 3'h7;
  localparam logic [2:0] MIN_CORE = 3'h1;
  localparam logic [7:0] RST_WD_COUNT = 8'h00;
  localparam logic [15:0] RST_LOCK_DELAY = 16'h0000;
  localparam logic [7:0] SAR_MID = 8'h80;
  localparam logic [7:0] SAR_TOP = 8'hFF;
  localparam logic [2:0] SAR_MSB = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BAND,
    ST_AMP_START,
    ST_AMP
  } vbc_fsm_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } vbc_bus_type;

  typedef struct packed {
    logic [2:0] core;
    logic [7:0] band;
    logic [7:0] amp;
  } vbc_osc_type;

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic pd_prev;
    logic trig_fcal;
    logic [2:0] start_core;
    logic core_override;
    logic band_override;
    logic amp_override;
    logic wd_enable;
    logic [7:0] manual_band;
    logic [7:0] manual_amp;
    logic [7:0] wd_restart_count;
    logic [7:0] wd_restarts;
    logic [15:0] wd_timer;
    logic wd_spent;
    logic [15:0] lock_delay_count;
    vbc_fsm_type fsm;
    logic [2:0] bit_idx;
    logic [2:0] settle;
    logic band_run;
    logic busy;
    vbc_osc_type osc;
    logic [15:0] ld_timer;
    logic ld_ok;
    logic [15:0] unlock_timer;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic irq;
    logic [15:0] rd_data;
  } vbc_state_type;

endpackage

// *** tb/vbc_band_cal_sva.sv ***
`timescale 1ns/1ps
module vbc_band_cal_sva import vbc_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire vbc_bus_type bus_i,
  input wire logic lock_i,
  input wire vbc_osc_type osc_o,
  input wire logic cal_busy_o,
  input wire logic lock_detect_o
);
  logic [6:0] asg;
  logic [15:0] man;
  logic trig;
  assign trig = bus_i.wr && (bus_i.addr == OFS_TRIGGER);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      asg <= {4'h0, RST_START_CORE};
      man <= 16'h0000;
    end else if (bus_i.wr && bus_i.addr == OFS_ASSIST) begin
      asg <= bus_i.wdata[6:0];
    end else if (bus_i.wr && bus_i.addr == OFS_MANUAL) begin
      man <= bus_i.wdata;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence full_trig_s;
    trig && bus_i.wdata[0] && (asg[5:3] == 3'h7);
  endsequence
  sequence locked_s;
    lock_i [*4] ##0 (lock_detect_o && !trig);
  endsequence
  trig_busy_a: assert property (trig |=> cal_busy_o)
    else $error("busy did not follow a trigger write");
  band_start_a: assert property (trig && bus_i.wdata[0] && !asg[4] |=>
    osc_o.core == asg[2:0] && osc_o.band == SAR_MID) else $error("search start wrong");
  osc_hold_a: assert property (!cal_busy_o && !trig |=> cal_busy_o || $stable(osc_o))
    else $error("settings moved while idle");
  busy_lock_a: assert property (cal_busy_o |-> !lock_detect_o)
    else $error("lock detect high while calibrating");
  full_assist_a: assert property (full_trig_s |-> ##[1:100]
    (!cal_busy_o && osc_o == {asg[2:0], man[7:0], man[15:8]})) else $error("forced values lost");
  busy_bound_a: assert property ($rose(cal_busy_o) && !asg[6] |-> ##[1:600] !cal_busy_o)
    else $error("calibration never finished");
  recal_start_a: assert property ($fell(lock_detect_o) |-> cal_busy_o)
    else $error("lock detect fell without calibration");
  lock_hold_a: assert property (locked_s |=> lock_detect_o)
    else $error("recalibration while locked");
endmodule // vbc_band_cal_sva
bind vbc_band_cal vbc_band_cal_sva chk (.clk_i, .sys_rst_i, .bus_i, .lock_i, .osc_o,
  .cal_busy_o, .lock_detect_o);

// *** tb/vbc_band_cal_test.sv ***
`timescale 1ns/1ps
module vbc_band_cal_test import vbc_pkg::*;;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  vbc_bus_type bus_i = '0;
  logic lock_i = 1'b1;
  logic relock_cal_pin_i = 1'b0;
  logic [7:0] tgt_amp = 8'h33;
  logic [15:0] rd_data_o;
  logic freq_above, amp_low, pd_tick, cal_busy_o, lock_detect_o, irq_o;
  vbc_osc_type osc_o;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #50 clk_i = ~clk_i;
  vbc_band_cal #(.WD_TIMEOUT_CYCLES(50)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .bus_i(bus_i), .rd_data_o(rd_data_o), .freq_above_i(freq_above), .amp_low_i(amp_low),
    .lock_i(lock_i), .pd_tick_i(pd_tick), .relock_cal_pin_i(relock_cal_pin_i), .osc_o(osc_o),
    .cal_busy_o(cal_busy_o), .lock_detect_o(lock_detect_o), .irq_o(irq_o));
  vbc_osc_model osc (.clk_i(clk_i), .osc_i(osc_o), .tgt_core_i(3'h3), .tgt_band_i(8'h5A),
    .tgt_amp_i(tgt_amp), .freq_above_o(freq_above), .amp_low_o(amp_low), .pd_tick_o(pd_tick));
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_lvl(input logic [15:0] e);
    @(negedge clk_i);
    chk({14'h0000, cal_busy_o, irq_o}, e);
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_i);
    bus_i <= '0;
    @(negedge clk_i);
    chk(rd_data_o, e);
    @(posedge clk_i);
  endtask
  task automatic idle();
    for (int i = 0; i < 2000 && cal_busy_o !== 1'b0; i++) @(negedge clk_i);
    chk({15'h0000, cal_busy_o}, 16'h0000);
    repeat (40) @(posedge clk_i);
  endtask
  task automatic cal(input logic [15:0] t, input logic [15:0] r, input logic [15:0] a);
    wr(OFS_TRIGGER, t);
    idle();
    rd(OFS_RESULT, r);
    rd(OFS_AMP_RESULT, a);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(OFS_RESULT, 16'h4700);
    rd(OFS_AMP_RESULT, 16'h0000);
    rd(OFS_IRQ_MASK, 16'h0000);
    rd(8'h24, 16'h0000);
    wr(OFS_ASSIST, 16'h0007);
    cal(16'h0001, 16'h435A, 16'h0033);
    rd(OFS_IRQ_STATUS, 16'h0001);
    chk_lvl(16'h0000);
    wr(OFS_IRQ_MASK, 16'h0001);
    chk_lvl(16'h0001);
    wr(OFS_IRQ_STATUS, 16'h0001);
    chk_lvl(16'h0000);
    wr(OFS_ASSIST, 16'h0005);
    cal(16'h0001, 16'h435A, 16'h0033);
    wr(OFS_ASSIST, 16'h000C);
    cal(16'h0001, 16'h44FF, 16'h0033);
    tgt_amp <= 8'h77;
    cal(16'h0000, 16'h44FF, 16'h0077);
    wr(OFS_MANUAL, 16'h21C4);
    wr(OFS_ASSIST, 16'h003F);
    cal(16'h0001, 16'h47C4, 16'h0021);
    wr(OFS_IRQ_STATUS, 16'h000F);
    wr(OFS_ASSIST, 16'h0047);
    wr(OFS_WATCHDOG, 16'h0002);
    cal(16'h0001, 16'h435A, 16'h0077);
    rd(OFS_WATCHDOG, 16'h0202);
    rd(OFS_IRQ_STATUS, 16'h000B);
    wr(OFS_ASSIST, 16'h0007);
    wr(OFS_LOCK_DELAY, 16'h0003);
    wr(OFS_IRQ_STATUS, 16'h000F);
    cal(16'h0001, 16'h435A, 16'h0077);
    lock_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    chk_lvl(16'h0001);
    relock_cal_pin_i <= 1'b1;
    for (int i = 0; i < 200 && cal_busy_o !== 1'b1; i++) @(posedge clk_i);
    lock_i <= 1'b1;
    chk_lvl(16'h0003);
    idle();
    rd(OFS_IRQ_STATUS, 16'h0005);
    rd(OFS_RESULT, 16'h435A);
    // A reset while idle and locked stands in for leaving power-down; the host must recalibrate after it.
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(OFS_RESULT, 16'h4700);
    rd(OFS_IRQ_STATUS, 16'h0000);
    cal(16'h0001, 16'h435A, 16'h0077);
    test_done();
  end
endmodule // vbc_band_cal_test

// *** tb/vbc_osc_model.sv ***
`timescale 1ns/1ps
module vbc_osc_model import vbc_pkg::*; (
  input wire logic clk_i,
  input wire vbc_osc_type osc_i,
  input wire logic [2:0] tgt_core_i,
  input wire logic [7:0] tgt_band_i,
  input wire logic [7:0] tgt_amp_i,
  output logic freq_above_o,
  output logic amp_low_o,
  output logic pd_tick_o
);
  logic [1:0] div = 2'h0;
  // Every band of a core above the target is too fast, so the search must step down.
  assign freq_above_o = (osc_i.core > tgt_core_i) ||
    ((osc_i.core == tgt_core_i) && (osc_i.band <= tgt_band_i));
  assign amp_low_o = osc_i.amp <= tgt_amp_i;
  // The reference keeps running, so the phase detector ticks every four clocks.
  always @(posedge clk_i) div <= div + 2'h1;
  assign pd_tick_o = div[1];
endmodule // vbc_osc_model
